// >>> rtl/mis_core.sv
`timescale 1ns/10ps
module mis_core
  import mis_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Program memory
  output logic [10:0]           pc,
  input  wire logic [13:0]      instr,
  // Data memory, read is combinational on addr
  output mis_mem_type           mem,
  input  wire logic [7:0]       mem_rdata,
  // Hardware stack
  output mis_stk_type           stk,
  input  wire logic [10:0]      stk_top,
  // Watchdog side and observed state
  output logic                  watchdog_clear,
  output logic                  halted,
  output logic                  retire,
  output mis_flags_type         flags,
  output logic [7:0]            work,
  output logic                  master_irq_enable,
  input  wire logic             wake
);
  // Wake is asynchronous; two stages first
  logic [1:0] wake_sync;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_sync <= 2'b00;
    end else begin
      wake_sync <= {wake_sync[0], wake};
    end
  end

  mis_state_type st;
  mis_state_type next_st;
  logic [5:0]    opc;       // Opcode field
  logic [7:0]    opd;       // Operand byte
  logic [7:0]    res;       // Result byte
  logic [4:0]    lo_sum;    // Adjusted low nibble
  logic [4:0]    hi_sum;    // Adjusted high nibble
  logic          nib_c;     // internal_nibble_carry
  logic          issue;     // Execute slot of instruction cycle

  assign opc   = instr[13:8];
  assign opd   = instr[7:0];
  assign issue = (st.phase == MIS_RUN) && (st.sub == CYC_LAST);

  ////////////////////////////////////////////////////////////////////
  // Execute: one instruction each four clocks
  always_comb begin
    next_st           = st;
    next_st.sub       = st.sub + 2'h1;
    next_st.wdt_clear = 1'b0;
    next_st.retire    = 1'b0;
    mem               = '{we: 1'b0, addr: opd[6:0], wdata: 8'h00};
    stk               = '{push: 1'b0, pop: 1'b0, data: 11'h000};
    res               = 8'h00;
    nib_c             = 1'b0;
    lo_sum            = {1'b0, st.work[3:0]};
    hi_sum            = {1'b0, st.work[7:4]};
    if (st.phase == MIS_HALT) begin
      next_st.sub = 2'h0;
      // Leave halt only on a synchronised wake
      if (wake_sync[1]) begin
        next_st.phase = MIS_RUN;
      end
    end else if (st.phase == MIS_EXTRA) begin
      // Dummy cycle after a return or a low pc byte write
      if (st.sub == CYC_LAST) begin
        next_st.phase = MIS_RUN;
      end
    end else if (issue) begin
      next_st.retire = 1'b1;
      next_st.pc     = st.pc + 11'h001;
      if (instr[13:11] == OP_GOTO) begin
        next_st.pc = instr[10:0];
      end else if (instr[13:11] == OP_CALL) begin
        stk        = '{push: 1'b1, pop: 1'b0, data: st.pc + 11'h001};
        next_st.pc = instr[10:0];
      end else begin
        unique case (opc)
          OP_WCLR: begin
            next_st.wdt_clear          = 1'b1;
            next_st.flags.sleep_flag   = 1'b0;
            next_st.flags.timeout_flag = 1'b0;
            next_st.pre_a              = 1'b0;
            next_st.pre_b              = 1'b0;
          end
          OP_WPA, OP_WPB: begin
            // Pair complete when the other one already ran
            if ((opc == OP_WPA) ? st.pre_b : st.pre_a) begin
              next_st.wdt_clear          = 1'b1;
              next_st.flags.sleep_flag   = 1'b0;
              next_st.flags.timeout_flag = 1'b0;
              next_st.pre_a              = 1'b0;
              next_st.pre_b              = 1'b0;
            end else if (opc == OP_WPA) begin
              next_st.pre_a = 1'b1;
            end else begin
              next_st.pre_b = 1'b1;
            end
          end
          OP_CPL, OP_COMPLEMENT_TO_WORK: begin
            res                = ~mem_rdata;
            next_st.flags.zero = (res == 8'h00);
            if (opc == OP_CPL) begin
              mem.we    = 1'b1;
              mem.wdata = res;
            end else begin
              next_st.work = res;
            end
          end
          OP_DAA: begin
            if ((lo_sum > BCD_MAX) || st.flags.half_carry_flag) begin
              lo_sum = lo_sum + BCD_ADJ;
              nib_c  = ~st.flags.half_carry_flag;
            end
            hi_sum = hi_sum + {4'h0, nib_c};
            if ((hi_sum > BCD_MAX) || st.flags.carry) begin
              hi_sum              = hi_sum + BCD_ADJ;
              next_st.flags.carry = 1'b1;
            end
            mem.we    = 1'b1;
            mem.wdata = {hi_sum[3:0], lo_sum[3:0]};
          end
          OP_DEC, OP_MINUS_ONE_TO_WORK, OP_INC, OP_PLUS_ONE_TO_WORK: begin
            res = ((opc == OP_DEC) || (opc == OP_MINUS_ONE_TO_WORK)) ? (mem_rdata - 8'h01)
                                                        : (mem_rdata + 8'h01);
            next_st.flags.zero = (res == 8'h00);
            if ((opc == OP_DEC) || (opc == OP_INC)) begin
              mem.we    = 1'b1;
              mem.wdata = res;
            end else begin
              next_st.work = res;
            end
          end
          OP_HALT: begin
            next_st.phase              = MIS_HALT;
            next_st.wdt_clear          = 1'b1;
            next_st.flags.sleep_flag   = 1'b1;
            next_st.flags.timeout_flag = 1'b0;
          end
          OP_MOVAM: next_st.work = mem_rdata;
          OP_MOVAX: next_st.work = opd;
          OP_MOVMA: begin
            mem.we    = 1'b1;
            mem.wdata = st.work;
          end
          OP_ORAM, OP_ORAX, OP_ORM: begin
            res                = st.work | ((opc == OP_ORAX) ? opd : mem_rdata);
            next_st.flags.zero = (res == 8'h00);
            if (opc == OP_ORM) begin
              mem.we    = 1'b1;
              mem.wdata = res;
            end else begin
              next_st.work = res;
            end
          end
          OP_RET, OP_RETX, OP_INTERRUPT_EXIT: begin
            stk.pop       = 1'b1;
            next_st.pc    = stk_top;
            next_st.phase = MIS_EXTRA;
            if (opc == OP_RETX) begin
              next_st.work = opd;
            end
            if (opc == OP_INTERRUPT_EXIT) begin
              next_st.master_irq_enable = 1'b1;
            end
          end
          OP_ROL: begin
            mem.we    = 1'b1;
            mem.wdata = {mem_rdata[6:0], mem_rdata[7]};
          end
          default: begin
            // Idle and unused codes only advance the pc
          end
        endcase
      end
      // A write to the low pc byte redirects and costs a cycle
      if (mem.we && (mem.addr == PCL_ADDR)) begin
        next_st.pc    = {st.pc[10:8], mem.wdata};
        next_st.phase = MIS_EXTRA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st       <= '0;
      st.phase <= MIS_RUN;
      st.pc    <= PC_RST;
      st.work  <= WDT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from state
  assign pc                = st.pc;
  assign watchdog_clear    = st.wdt_clear;
  assign halted            = (st.phase == MIS_HALT);
  assign retire            = st.retire;
  assign flags             = st.flags;
  assign work              = st.work;
  assign master_irq_enable = st.master_irq_enable;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  wclr_flags_a: assert property (issue && opc == OP_WCLR && instr[13] == 1'b0
    |=> watchdog_clear && !flags.sleep_flag && !flags.timeout_flag)
    else $error("watchdog clear failed");
  pre_lone_a: assert property (issue && opc == OP_WPA && !st.pre_b && !instr[13]
    |=> !watchdog_clear && st.pre_a && $stable(flags.timeout_flag))
    else $error("lone preclear cleared watchdog");
  pre_pair_a: assert property (issue && opc == OP_WPB && st.pre_a && !instr[13]
    |=> watchdog_clear && !flags.timeout_flag)
    else $error("preclear pair failed");
  cpl_write_a: assert property (issue && opc == OP_CPL && !instr[13]
    |-> mem.we && mem.wdata == ~mem_rdata)
    else $error("complement write wrong");
  halt_enter_a: assert property (issue && opc == OP_HALT && !instr[13]
    |=> halted && flags.sleep_flag && watchdog_clear && pc == $past(pc) + 11'h001)
    else $error("halt entry wrong");
  goto_pc_a: assert property (issue && instr[13:11] == OP_GOTO
    |=> pc == $past(instr[10:0]) && $stable(flags))
    else $error("jump target wrong");
  ret_time_a: assert property (issue && opc == OP_RET && !instr[13]
    |=> pc == $past(stk_top) && !issue ##1 !issue [*6] ##1 issue)
    else $error("return timing wrong");
  interrupt_exit_irq_a: assert property (issue && opc == OP_INTERRUPT_EXIT && !instr[13]
    |=> master_irq_enable)
    else $error("irq enable not set");
  rol_data_a: assert property (issue && opc == OP_ROL && !instr[13]
    |-> mem.wdata == {mem_rdata[6:0], mem_rdata[7]})
    else $error("rotate wrong");
  call_push_a: assert property (issue && instr[13:11] == OP_CALL
    |-> stk.push && stk.data == pc + 11'h001)
    else $error("call push wrong");
  // Complement to work leaves memory alone
  complement_to_work_work_a: assert property (issue && opc == OP_COMPLEMENT_TO_WORK && !instr[13]
    |-> !mem.we ##1 work == ~$past(mem_rdata) && flags.zero == (work == 8'h00))
    else $error("complement to work wrong");
  // Decrement and increment in place
  dec_mem_a: assert property (issue && opc == OP_DEC && !instr[13]
    |-> mem.we && mem.wdata == mem_rdata - 8'h01)
    else $error("decrement write wrong");
  inc_mem_a: assert property (issue && opc == OP_INC && !instr[13]
    |-> mem.we && mem.wdata == mem_rdata + 8'h01)
    else $error("increment write wrong");
  // Work variants touch only work and zero
  minus_one_to_work_work_a: assert property (issue && opc == OP_MINUS_ONE_TO_WORK && !instr[13]
    |-> !mem.we ##1 work == $past(mem_rdata) - 8'h01 && flags.zero == (work == 8'h00))
    else $error("decrement to work wrong");
  plus_one_to_work_work_a: assert property (issue && opc == OP_PLUS_ONE_TO_WORK && !instr[13]
    |-> !mem.we ##1 work == $past(mem_rdata) + 8'h01 && flags.zero == (work == 8'h00))
    else $error("increment to work wrong");
  // Low nibble of decimal adjust, half carry included
  daa_low_a: assert property (issue && opc == OP_DAA && !instr[13]
    |-> mem.we && mem.wdata[3:0] == ((work[3:0] > 4'h9 || flags.half_carry_flag)
      ? work[3:0] + 4'h6 : work[3:0]))
    else $error("decimal adjust low nibble wrong");
  // Moves never touch the flags
  move_flags_a: assert property (issue && !instr[13]
    && (opc == OP_MOVAM || opc == OP_MOVAX || opc == OP_MOVMA) |=> $stable(flags))
    else $error("move changed flags");
  // OR results, to work and to memory
  or_work_a: assert property (issue && opc == OP_ORAX && !instr[13]
    |=> work == ($past(work) | $past(opd)) && flags.zero == (work == 8'h00))
    else $error("or to work wrong");
  orm_mem_a: assert property (issue && opc == OP_ORM && !instr[13]
    |-> mem.we && mem.wdata == (work | mem_rdata))
    else $error("or to memory wrong");
  // Halt keeps work, clears timeout
  halt_flags_a: assert property (issue && opc == OP_HALT && !instr[13]
    |=> !flags.timeout_flag && $stable(work))
    else $error("halt flags wrong");
  // Idle moves nothing but the pc
  idle_pc_a: assert property (issue && opc == OP_IDLE && !instr[13]
    |-> !mem.we && !stk.push ##1 pc == $past(pc) + 11'h001 && $stable(work))
    else $error("idle changed state");
  // Literal return loads work, flags untouched
  retx_work_a: assert property (issue && opc == OP_RETX && !instr[13]
    |=> work == $past(opd) && $stable(flags))
    else $error("literal return wrong");
  // Rotate leaves every flag alone
  rol_flags_a: assert property (issue && opc == OP_ROL && !instr[13]
    |-> mem.we ##1 $stable(flags))
    else $error("rotate changed flags");
  // Low pc byte write redirects and adds a cycle
  pcl_extra_a: assert property (issue && mem.we && mem.addr == PCL_ADDR
    |=> pc[7:0] == $past(mem.wdata) && !issue ##1 !issue [*6] ##1 issue)
    else $error("low pc byte write wrong");

  cov_halt_c: cover property (issue && opc == OP_HALT ##[1:20] !halted);
  cov_pair_c: cover property (issue && opc == OP_WPA ##[4:40] issue && opc == OP_WPB);
  cov_pcl_c: cover property (issue && mem.we && mem.addr == PCL_ADDR);
  // Return spacing and wake from halt
  cov_ret_c: cover property (issue && opc == OP_RET && !instr[13] ##8 issue);
  cov_wake_c: cover property (halted ##1 !halted);
endmodule : mis_core

// >>> rtl/mis_pkg.sv
// Function
// - Watchdog clear zeroes counter, clears sleep, timeout
// - Paired preclears zero counter and clear flags
// - Lone preclear only records itself
// - Complement memory byte in place, zero flag
// - Complement to work register, zero flag
// - Decimal adjust low nibble, nibble carry
// - Decimal adjust high nibble, sets carry
// - Decrement to memory or work, zero flag
// - Increment to memory or work, zero flag
// - Halt stops execution after pc advance
// - Halt clears watchdog, sets sleep, clears timeout
// - Jump loads pc from instruction, no flags
// - Moves copy immediate or memory, no flags
// - Idle only advances pc
// - OR into work register, zero flag
// - OR written back to memory, zero flag
// - Subroutine exit pops pc, two cycles
// - Exit with literal pops pc, loads work
// - Interrupt exit pops pc, sets irq enable
// - Rotate left in place, no flags
// - Call pushes next address, loads target
// - Low pc byte write adds one cycle
package mis_pkg;
  // Instruction and data widths
  localparam int MIS_IW = 14;
  localparam int MIS_PW = 11;
  localparam int MIS_AW = 7;
  // Opcode field in bits 13:8 (operand in 7:0, address in 10:0 for jumps)
  localparam logic [5:0] OP_IDLE  = 6'h00;
  localparam logic [5:0] OP_WCLR  = 6'h01;
  localparam logic [5:0] OP_WPA   = 6'h02;
  localparam logic [5:0] OP_WPB   = 6'h03;
  localparam logic [5:0] OP_CPL   = 6'h04;
  localparam logic [5:0] OP_COMPLEMENT_TO_WORK  = 6'h05;
  localparam logic [5:0] OP_DAA   = 6'h06;
  localparam logic [5:0] OP_DEC   = 6'h07;
  localparam logic [5:0] OP_MINUS_ONE_TO_WORK  = 6'h08;
  localparam logic [5:0] OP_INC   = 6'h09;
  localparam logic [5:0] OP_PLUS_ONE_TO_WORK  = 6'h0a;
  localparam logic [5:0] OP_HALT  = 6'h0b;
  localparam logic [5:0] OP_MOVAM = 6'h0c;
  localparam logic [5:0] OP_MOVAX = 6'h0d;
  localparam logic [5:0] OP_MOVMA = 6'h0e;
  localparam logic [5:0] OP_ORAM  = 6'h0f;
  localparam logic [5:0] OP_ORAX  = 6'h10;
  localparam logic [5:0] OP_ORM   = 6'h11;
  localparam logic [5:0] OP_RET   = 6'h12;
  localparam logic [5:0] OP_RETX  = 6'h13;
  localparam logic [5:0] OP_INTERRUPT_EXIT  = 6'h14;
  localparam logic [5:0] OP_ROL   = 6'h15;
  localparam logic [2:0] OP_GOTO  = 3'h4; // bits 13:11, address in 10:0
  localparam logic [2:0] OP_CALL  = 3'h5;
  // Data address of the low pc byte register
  localparam logic [6:0] PCL_ADDR = 7'h02;
  // Reset values and decimal constants
  localparam logic [10:0] PC_RST  = 11'h000;
  localparam logic [7:0]  WDT_RST = 8'h00;
  localparam logic [4:0]  BCD_MAX = 5'h09;
  localparam logic [4:0]  BCD_ADJ = 5'h06;
  // Last clock of the instruction cycle, four clocks each
  localparam logic [1:0]  CYC_LAST = 2'h3;

  typedef enum logic [1:0] {
    MIS_RUN   = 2'b00,
    MIS_EXTRA = 2'b01,
    MIS_HALT  = 2'b10
  } mis_phase_type;

  // Status flags
  typedef struct packed {
    logic timeout_flag;
    logic sleep_flag;
    logic zero;
    logic carry;
    logic half_carry_flag;
  } mis_flags_type;

  // Data memory request
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mis_mem_type;

  // Stack request
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [10:0] data;
  } mis_stk_type;

  // Core state, all but the wake synchroniser
  typedef struct packed {
    mis_phase_type phase;
    logic [1:0]    sub;
    logic [10:0]   pc;
    logic [7:0]    work;
    mis_flags_type flags;
    logic          master_irq_enable;
    logic          pre_a;
    logic          pre_b;
    logic          wdt_clear;
    logic          retire;
  } mis_state_type;
endpackage : mis_pkg

// >>> tb/mis_mem_model.sv
`timescale 1ns/10ps
module mis_mem_model
  import mis_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Program side
  input  wire logic [10:0] pc,
  output logic [13:0]      instr,
  // Data and stack side
  input  wire mis_mem_type mem,
  output logic [7:0]       mem_rdata,
  input  wire mis_stk_type stk,
  output logic [10:0]      stk_top
);
  logic [13:0] rom [0:127] = '{default: 14'h0000}; // Program, bench fills
  logic [7:0]  ram [0:127] = '{default: 8'h00};    // Data bytes
  logic [10:0] stack [0:7];                        // Return addresses
  logic [2:0]  sp = 3'h0;                          // Entries in use
  ////////////////////////////////////////////////////////////////
  // Reads are combinational; an empty stack shows a bogus value
  assign instr     = rom[pc[6:0]];
  assign mem_rdata = ram[mem.addr];
  assign stk_top   = (sp == 3'h0) ? 11'h5a5 : stack[sp - 3'h1];
  // Writes, pushes and pops land on the clock edge
  always @(posedge clk_sys) begin
    if (mem.we) begin
      ram[mem.addr] <= mem.wdata;
    end
    if (stk.push) begin
      stack[sp] <= stk.data;
      sp        <= sp + 3'h1;
    end else if (stk.pop) begin
      sp <= sp - 3'h1;
    end
  end
endmodule : mis_mem_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import mis_pkg::*;
;
  logic          clk_sys = 1'b0; // System clock
  logic          sys_rst;        // Reset
  logic          wake;           // Halt release
  logic [10:0]   pc;
  logic [13:0]   instr;
  mis_mem_type   mem;
  logic [7:0]    mem_rdata;
  mis_stk_type   stk;
  logic [10:0]   stk_top;
  logic          watchdog_clear;
  logic          halted;
  logic          retire;
  mis_flags_type flags;
  logic [7:0]    work;
  logic          master_irq_enable;
  int            n_errors;       // Mismatches
  int            checked;        // Comparisons
  int            gap;            // Clocks of the last step
  int            cyc = 0;        // Timeout counter
  logic          wd_seen;        // Watchdog clear seen in step
  ////////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  mis_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pc(pc), .instr(instr), .mem(mem),
    .mem_rdata(mem_rdata), .stk(stk), .stk_top(stk_top), .watchdog_clear(watchdog_clear),
    .halted(halted), .retire(retire), .flags(flags), .work(work),
    .master_irq_enable(master_irq_enable), .wake(wake));
  mis_mem_model i_mem (.clk_sys(clk_sys), .pc(pc), .instr(instr), .mem(mem),
    .mem_rdata(mem_rdata), .stk(stk), .stk_top(stk_top));
  ////////////////////////////////////////////////////////////////
  // Cycle count for the hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // Hang guard, run needs under two hundred clocks
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task ld(input logic [10:0] a, input logic [13:0] w);
    i_mem.rom[a[6:0]] = w;
  endtask : ld
  // One instruction: wait for its retire pulse, bounded
  task step;
    gap     = 0;
    wd_seen = 1'b0;
    do begin
      @(negedge clk_sys);
      gap = gap + 1;
      // Pulse rises with retire, so catch it at the same falling edge
      if (watchdog_clear === 1'b1) begin
        wd_seen = 1'b1;
      end
    end while (retire !== 1'b1 && gap < 40);
  endtask : step
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_rst  = 1'b1;
    wake     = 1'b0;
    n_errors = 0;
    checked  = 0;
    #1;
    // Program and data preload
    ld(11'h000, {OP_MOVAX, 8'h99}); ld(11'h001, {OP_MOVMA, 8'h05});
    ld(11'h002, {OP_CPL, 8'h05});   ld(11'h003, {OP_COMPLEMENT_TO_WORK, 8'h05});
    ld(11'h004, {OP_INC, 8'h06});   ld(11'h005, {OP_MINUS_ONE_TO_WORK, 8'h06});
    ld(11'h006, {OP_DEC, 8'h07});   ld(11'h007, {OP_MOVAX, 8'h00});
    ld(11'h008, {OP_PLUS_ONE_TO_WORK, 8'h07});  ld(11'h009, {OP_MOVAX, 8'h00});
    ld(11'h00a, {OP_ORAM, 8'h08});  ld(11'h00b, {OP_ROL, 8'h0a});
    ld(11'h00c, {OP_ORAX, 8'h30});  ld(11'h00d, {OP_ORM, 8'h09});
    ld(11'h00e, {OP_MOVAX, 8'h9a}); ld(11'h00f, {OP_DAA, 8'h0b});
    ld(11'h010, {OP_WPA, 8'h00});   ld(11'h011, {OP_WPB, 8'h00});
    ld(11'h012, {OP_WCLR, 8'h00});  ld(11'h013, {OP_CALL, 11'h020});
    ld(11'h020, {OP_RETX, 8'h5a});  ld(11'h014, {OP_GOTO, 11'h030});
    ld(11'h030, {OP_CALL, 11'h040}); ld(11'h040, {OP_INTERRUPT_EXIT, 8'h00});
    ld(11'h031, {OP_CALL, 11'h050}); ld(11'h050, {OP_RET, 8'h00});
    ld(11'h033, {OP_HALT, 8'h00});  ld(11'h034, {OP_WPA, 8'h00});
    ld(11'h035, {OP_WPB, 8'h00});   ld(11'h036, {OP_MOVAM, 8'h05});
    ld(11'h037, {OP_MOVAX, 8'h60}); ld(11'h038, {OP_MOVMA, 1'b0, PCL_ADDR});
    i_mem.ram[6] = 8'hff; i_mem.ram[7] = 8'h01; i_mem.ram[9] = 8'h05;
    i_mem.ram[10] = 8'h81; i_mem.ram[11] = 8'h00;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    step; chk("work", 11'h099, {3'h0, work});
    step; chk("mem5", 11'h099, {3'h0, i_mem.ram[5]});
    step; chk("mem5", 11'h066, {3'h0, i_mem.ram[5]});
    step; chk("work", 11'h099, {3'h0, work});
    chk("mem5", 11'h066, {3'h0, i_mem.ram[5]});
    step; chk("mem6", 11'h000, {3'h0, i_mem.ram[6]});
    chk("flags", 11'h004, {6'h0, flags});
    step; chk("work", 11'h0ff, {3'h0, work});
    chk("flags", 11'h000, {6'h0, flags});
    step; chk("mem7", 11'h000, {3'h0, i_mem.ram[7]});
    step; chk("flags", 11'h004, {6'h0, flags});
    step; chk("work", 11'h001, {3'h0, work});
    chk("flags", 11'h000, {6'h0, flags});
    step;
    step; chk("flags", 11'h004, {6'h0, flags});
    step; chk("mem10", 11'h003, {3'h0, i_mem.ram[10]});
    chk("flags", 11'h004, {6'h0, flags});
    step; chk("work", 11'h030, {3'h0, work});
    step; chk("mem9", 11'h035, {3'h0, i_mem.ram[9]});
    chk("work", 11'h030, {3'h0, work});
    step;
    step; chk("mem11", 11'h000, {3'h0, i_mem.ram[11]});
    chk("flags", 11'h002, {6'h0, flags});
    step; chk("wdclr", 11'h000, {10'h0, wd_seen});
    step; chk("wdclr", 11'h001, {10'h0, wd_seen});
    step; chk("wdclr", 11'h001, {10'h0, wd_seen});
    step; chk("pc", 11'h020, pc);
    step; chk("pc", 11'h014, pc);
    chk("work", 11'h05a, {3'h0, work});
    step; chk("pc", 11'h030, pc);
    step;
    step; chk("pc", 11'h031, pc);
    chk("irq_en", 11'h001, {10'h0, master_irq_enable});
    step;
    step; chk("pc", 11'h032, pc);
    step; chk("gap", 11'h008, gap[10:0]);
    chk("pc", 11'h033, pc);
    step; chk("pc", 11'h034, pc);
    chk("flags", 11'h00a, {6'h0, flags});
    chk("wdclr", 11'h001, {10'h0, wd_seen});
    repeat (12) @(negedge clk_sys);
    chk("halted", 11'h001, {10'h0, halted});
    chk("pc", 11'h034, pc);
    wake = 1'b1;
    step; chk("flags", 11'h00a, {6'h0, flags});
    chk("wdclr", 11'h000, {10'h0, wd_seen});
    wake = 1'b0;
    step; chk("flags", 11'h002, {6'h0, flags});
    chk("wdclr", 11'h001, {10'h0, wd_seen});
    step; chk("work", 11'h066, {3'h0, work});
    step; chk("work", 11'h060, {3'h0, work});
    step; chk("pc", 11'h060, pc);
    step; chk("gap", 11'h008, gap[10:0]);
    chk("pc", 11'h061, pc);
    report_and_stop();
  end
endmodule : tb_top
